// file: rtl/cber_pkg.sv
package cber_pkg;

  // register byte offsets
  localparam logic [11:0] CBER_OFF_ERR  = 12'h000;
  localparam logic [11:0] CBER_OFF_CTRL = 12'h004;
  localparam logic [11:0] CBER_OFF_STAT = 12'h008;

  // bus_error_register: address-bus error bits and hard/fault source field positions
  localparam int CBER_APE    = 0;
  localparam int CBER_ADDRESS_XMIT_CHECK_ERR   = 1;
  localparam int CBER_REQUEST_XMIT_CHECK_ERR   = 2;
  localparam int CBER_ACK_XMIT_CHECK_ERR = 3;
  localparam int CBER_ARB_BUS_XMIT_CHECK_ERR  = 4;
  localparam int CBER_NAE    = 5;
  localparam int CBER_FATAL_NO_ACK_ERR   = 6;
  localparam int CBER_HARD_LSB  = 16;
  localparam int CBER_FAULT_LSB = 24;
  localparam int CBER_SRC_W     = 8;

  // hard source order: uncorr data, sys addr, sys data, tag data par,
  // tag status par, chip csr par, chip addr par, local bus timeout
  localparam logic [7:0] CBER_HARD_DATA_MASK = 8'h05;

  // control register fields
  localparam int CBER_CTRL_NID_LSB = 0;
  localparam int CBER_CTRL_VID_LSB = 4;
  localparam int CBER_CTRL_MEM     = 8;
  localparam logic [31:0] CBER_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CBER_CTRL_MASK = 32'h0000_01f7;

  // driven or sampled command/address field group
  typedef struct packed {
    logic [39:3] adr;
    logic        adr_par;
    logic [2:0]  cmd;
    logic        cmd_par;
    logic [3:0]  bank;
  } cber_abus_t;

  // missing acknowledge report from the commander logic
  typedef struct packed {
    logic valid;
    logic csr;
    logic read;
    logic mbox_wr;
  } cber_noack_t;

endpackage : cber_pkg

// file: rtl/cber_unit.sv
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module cber_unit
  import cber_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        cmd_drive,
  input  wire cber_abus_t  abus_drv,
  input  wire cber_abus_t  abus_rx,
  input  wire logic        abus_valid,
  input  wire logic        req_drive,
  input  wire logic [7:0]  bus_request_lines,
  input  wire logic        ack_drive,
  input  wire logic        bus_command_acknowledge,
  input  wire logic        sup_drive,
  input  wire logic        bus_arbitration_suppress,
  input  wire logic        avl_drive,
  input  wire logic [15:0] bus_bank_available,
  input  wire cber_noack_t noack,
  input  wire logic [7:0]  hard_src,
  input  wire logic [7:0]  fault_src,
  input  wire logic        bus_fault_line_i,
  output logic             bus_fault_line_o,
  output logic             bus_fault_line_oe_n,
  input  wire logic        bus_data_error_line_i,
  output logic             bus_data_error_line_o,
  output logic             bus_data_error_line_oe_n,
  output logic             system_machine_check_irq,
  output logic             cpu_fail_wire,
  output logic             cpu_fail_acknowledge,
  output logic             fill_error
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when a group carries even parity; zero padding keeps parity
  function automatic logic cber_even(input logic [63:0] v);
    return ~(^v);
  endfunction : cber_even

  logic [31:0] err_q;
  logic [31:0] err_d;
  logic [31:0] ctrl_q;
  logic [31:0] prdata_q;
  logic        fault_drv_q;
  logic        derr_drv_q;
  logic        fault_seen_q;
  logic        fail_q;
  logic        fill_q;
  logic [2:0]  nid;
  logic [3:0]  vid;
  logic        mem_node;
  logic        adr_mis;
  logic        req_mis;
  logic        ack_mis;
  logic        sup_mis;
  logic        avl_mis;
  logic        par_err;
  logic        nae_set;
  logic        fatal_no_ack_err_set;
  logic        csr_nxm;
  logic [31:0] set_vec;
  logic [31:0] fault_bits;
  logic        new_fault;
  logic        new_derr;
  logic        wr_acc;
  logic        rd_setup;
  logic        hit;

  assign nid      = ctrl_q[CBER_CTRL_NID_LSB +: 3];
  assign vid      = ctrl_q[CBER_CTRL_VID_LSB +: 4];
  assign mem_node = ctrl_q[CBER_CTRL_MEM];

  ////////////////////////////////////////////////////////////////////////////
  // transmit checks

  // whole command/address group compared both ways while we own the bus
  assign adr_mis = cmd_drive && (abus_drv != abus_rx);
  // own request line is single-driven, so compare both levels
  assign req_mis = (bus_request_lines[nid] != req_drive);
  // shared lines: only driven-high, seen-low counts
  assign ack_mis = ack_drive && !bus_command_acknowledge;
  assign sup_mis = sup_drive && !bus_arbitration_suppress;
  // only a memory node owns a bank-available line
  assign avl_mis = mem_node && (bus_bank_available[vid] != avl_drive);

  ////////////////////////////////////////////////////////////////////////////
  // command field parity; a correct sender always gives odd parity

  assign par_err = abus_valid &&
                   (cber_even({37'h0, abus_rx.adr[30:5], abus_rx.adr_par}) ||
                    cber_even({45'h0, abus_rx.adr[39:31], abus_rx.adr[4:3],
                               abus_rx.cmd, abus_rx.bank, abus_rx.cmd_par}));

  ////////////////////////////////////////////////////////////////////////////
  // missing acknowledge classification

  // mailbox writes are legitimately unacknowledged
  assign nae_set  = noack.valid && noack.csr && !noack.mbox_wr;
  assign fatal_no_ack_err_set = noack.valid && !noack.csr;
  // csr read miss is a sizing probe: fill error, never a fault
  assign csr_nxm  = noack.valid && noack.csr && noack.read;

  ////////////////////////////////////////////////////////////////////////////
  // error sets and classification

  always_comb
  begin
    set_vec = '0;
    set_vec[CBER_APE]    = par_err;
    set_vec[CBER_ADDRESS_XMIT_CHECK_ERR]   = adr_mis;
    set_vec[CBER_REQUEST_XMIT_CHECK_ERR]   = req_mis;
    set_vec[CBER_ACK_XMIT_CHECK_ERR] = ack_mis;
    set_vec[CBER_ARB_BUS_XMIT_CHECK_ERR]  = sup_mis || avl_mis;
    set_vec[CBER_NAE]    = nae_set;
    set_vec[CBER_FATAL_NO_ACK_ERR]   = fatal_no_ack_err_set;
    set_vec[CBER_HARD_LSB +: CBER_SRC_W]  = hard_src;
    set_vec[CBER_FAULT_LSB +: CBER_SRC_W] = fault_src;
  end

  // fault-class bits; ack check and csr miss deliberately absent
  always_comb
  begin
    fault_bits = '0;
    fault_bits[CBER_APE]   = 1'b1;
    fault_bits[CBER_ADDRESS_XMIT_CHECK_ERR]  = 1'b1;
    fault_bits[CBER_REQUEST_XMIT_CHECK_ERR]  = 1'b1;
    fault_bits[CBER_ARB_BUS_XMIT_CHECK_ERR] = 1'b1;
    fault_bits[CBER_FATAL_NO_ACK_ERR]  = 1'b1;
    fault_bits[CBER_FAULT_LSB +: CBER_SRC_W] = '1;
  end

  // every new event pulses the line again, so repeats stay visible
  assign new_fault = |(set_vec & fault_bits);
  assign new_derr  = |(hard_src & CBER_HARD_DATA_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait, unmapped reads zero with slave error

  assign hit      = (paddr == CBER_OFF_ERR) || (paddr == CBER_OFF_CTRL) ||
                    (paddr == CBER_OFF_STAT);
  assign wr_acc   = psel && penable && pwrite && hit;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign prdata   = prdata_q;

  // write-one-to-clear; a set in the same cycle wins over the clear
  always_comb
  begin
    err_d = err_q;
    if (wr_acc && (paddr == CBER_OFF_ERR))
    begin
      err_d = err_q & ~pwdata;
    end
    err_d = err_d | set_vec;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      err_q <= '0;
    end
    else
    begin
      err_q <= err_d;
    end
  end

  // control register: node id, virtual id, memory node enable
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= CBER_CTRL_RST;
    end
    else if (wr_acc && (paddr == CBER_OFF_CTRL))
    begin
      ctrl_q <= pwdata & CBER_CTRL_MASK;
    end
  end

  // read data captured in setup so it is a flop in the access phase
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata_q <= '0;
    end
    else if (rd_setup)
    begin
      case (paddr)
        CBER_OFF_ERR:  prdata_q <= err_q;
        CBER_OFF_CTRL: prdata_q <= ctrl_q;
        CBER_OFF_STAT: prdata_q <= {28'h0, fail_q, system_machine_check_irq,
                                    bus_data_error_line_i, bus_fault_line_i};
        default:       prdata_q <= '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus line drivers; enable low while driving

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fault_drv_q <= 1'b0;
      derr_drv_q  <= 1'b0;
    end
    else
    begin
      fault_drv_q <= new_fault;
      derr_drv_q  <= new_derr;
    end
  end

  assign bus_fault_line_o         = fault_drv_q;
  assign bus_fault_line_oe_n      = ~fault_drv_q;
  assign bus_data_error_line_o    = derr_drv_q;
  assign bus_data_error_line_oe_n = ~derr_drv_q;

  ////////////////////////////////////////////////////////////////////////////
  // processor reporting

  // interrupt stays up until software clears every hard bit and the NAE bit
  assign system_machine_check_irq =
    |err_q[CBER_HARD_LSB +: CBER_SRC_W] || err_q[CBER_NAE];

  // fail without acknowledge is the unmaskable machine check that
  // resets the processor interface but leaves it able to log
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      fault_seen_q <= 1'b0;
      fail_q       <= 1'b0;
      fill_q       <= 1'b0;
    end
    else
    begin
      fault_seen_q <= bus_fault_line_i;
      fail_q       <= bus_fault_line_i && !fault_seen_q;
      fill_q       <= csr_nxm;
    end
  end

  assign cpu_fail_wire        = fail_q;
  assign cpu_fail_acknowledge = 1'b0;
  assign fill_error           = fill_q;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_csr_miss;
    noack.valid && noack.csr && noack.read && !noack.mbox_wr;
  endsequence

  sequence s_quiet;
    !(adr_mis || req_mis || sup_mis || avl_mis || par_err || (|fault_src));
  endsequence

  a_addr_xmit_fault: assert property (
    adr_mis |=> err_q[CBER_ADDRESS_XMIT_CHECK_ERR] && bus_fault_line_o && !bus_fault_line_oe_n)
    else $error("address transmit check not reported");

  a_req_xmit_fault: assert property (
    (bus_request_lines[nid] != req_drive) |=> err_q[CBER_REQUEST_XMIT_CHECK_ERR] && bus_fault_line_o)
    else $error("request transmit check not reported");

  a_ack_no_fault: assert property (
    (ack_drive && !bus_command_acknowledge) ##0 s_quiet ##0 !noack.valid
      |=> err_q[CBER_ACK_XMIT_CHECK_ERR] && !bus_fault_line_o)
    else $error("ack check wrong");

  a_sup_xmit_fault: assert property (
    (sup_drive && !bus_arbitration_suppress) |=> err_q[CBER_ARB_BUS_XMIT_CHECK_ERR] && bus_fault_line_o)
    else $error("arbitration suppress check not reported");

  a_avl_xmit_fault: assert property (
    (mem_node && bus_bank_available[vid] != avl_drive) |=> err_q[CBER_ARB_BUS_XMIT_CHECK_ERR])
    else $error("bank available check not reported");

  a_parity_fault: assert property (
    par_err |=> err_q[CBER_APE] && bus_fault_line_o)
    else $error("parity error not reported");

  a_csr_miss_fill: assert property (
    s_csr_miss ##0 s_quiet |=> fill_error && err_q[CBER_NAE] && !bus_fault_line_o)
    else $error("csr read miss handled wrong");

  a_mem_miss_fatal: assert property (
    (noack.valid && !noack.csr) |=> err_q[CBER_FATAL_NO_ACK_ERR] && bus_fault_line_o)
    else $error("memory miss not fatal");

  a_fail_on_fault: assert property (
    $rose(bus_fault_line_i) |=> cpu_fail_wire ##1 !cpu_fail_wire)
    else $error("fail wire not pulsed");

  a_hard_irq: assert property (
    (|hard_src) |=> system_machine_check_irq)
    else $error("hard error without interrupt");

  a_data_err_line: assert property (
    ((hard_src & CBER_HARD_DATA_MASK) == 8'h00) |=> !bus_data_error_line_o)
    else $error("data error line driven wrongly");

  a_fault_src_line: assert property (
    (|fault_src) |=> bus_fault_line_o && !bus_fault_line_oe_n)
    else $error("fault source did not drive fault line");

  a_fault_line_quiet: assert property (
    s_quiet ##0 !(noack.valid && !noack.csr) |=> !bus_fault_line_o)
    else $error("fault line driven without fault event");

  a_data_line_set: assert property (
    (|(hard_src & CBER_HARD_DATA_MASK)) |=> bus_data_error_line_o && !bus_data_error_line_oe_n)
    else $error("data hard error did not drive data error line");

  a_fill_only_miss: assert property (
    !(noack.valid && noack.csr && noack.read) |=> !fill_error)
    else $error("fill error without csr read miss");

  a_mailbox_exempt: assert property (
    (noack.valid && noack.csr && noack.mbox_wr && !err_q[CBER_NAE]) |=> !err_q[CBER_NAE])
    else $error("mailbox write miss flagged");

  a_fail_quiet: assert property (
    !bus_fault_line_i |=> !cpu_fail_wire)
    else $error("fail wire without fault line");

  a_req_level_quiet: assert property (
    (!err_q[CBER_REQUEST_XMIT_CHECK_ERR] && bus_request_lines[nid] == req_drive) |=> !err_q[CBER_REQUEST_XMIT_CHECK_ERR])
    else $error("request check flagged a matching level");

  a_avl_check_off: assert property (
    (!mem_node && !err_q[CBER_ARB_BUS_XMIT_CHECK_ERR] && !(sup_drive && !bus_arbitration_suppress))
      |=> !err_q[CBER_ARB_BUS_XMIT_CHECK_ERR])
    else $error("bank available checked on a non-memory node");

endmodule : cber_unit

// file: testbench/cber_bus_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// far side of the bus: resolves every wire from our drives, with injected faults
module cber_bus_model
  import cber_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [5:0] fl,
  input  wire logic [2:0] nid,
  input  wire logic [3:0] vid,
  input  wire cber_abus_t abus_drv,
  input  wire logic       req_drive,
  input  wire logic       ack_drive,
  input  wire logic       sup_drive,
  input  wire logic       avl_drive,
  input  wire logic       flt_o,
  input  wire logic       flt_oe_n,
  input  wire logic       dat_o,
  input  wire logic       dat_oe_n,
  output cber_abus_t      abus_rx,
  output logic [7:0]      req_lines,
  output logic            ack_line,
  output logic            sup_line,
  output logic [15:0]     avl_lines,
  output logic            flt_i,
  output logic            dat_i
);
  logic ext_q;

  // another node raises its fault from a flop, as a real driver would
  always_ff @(posedge clock)
    ext_q <= fl[5];

  // wired lines; a released fault or data line sits at its pull-down level
  assign abus_rx   = abus_drv ^ {38'h0, fl[0], 9'h0};
  assign req_lines = 8'(req_drive ^ fl[1]) << nid;
  assign ack_line  = ack_drive ^ fl[2]; // someone else may ack too
  assign sup_line  = sup_drive & !fl[3];
  assign avl_lines = 16'(avl_drive ^ fl[4]) << vid;
  assign flt_i     = (!flt_oe_n & flt_o) | ext_q;
  assign dat_i     = !dat_oe_n & dat_o;
endmodule : cber_bus_model

// file: testbench/cber_unit_test.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module cber_unit_test
  import cber_pkg::*;
;
  typedef struct packed {
    logic [5:0]  dv;
    logic [5:0]  fl;
    logic [3:0]  nk;
    logic [7:0]  hs;
    logic [7:0]  fs;
    logic [31:0] err;
    logic [2:0]  ex;
  } cber_tb_row_t;
  // good command cycle: odd parity on both groups
  localparam cber_abus_t  GOOD = 48'h110;
  localparam logic [31:0] CTRL = 32'h0000_0153;

  logic         clock = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, rv;
  logic         pready, pslverr, re;
  logic         cmd_drive = 0, abus_valid = 0, req_drive = 0, ack_drive = 0;
  logic         sup_drive = 0, avl_drive = 0;
  cber_abus_t   abus_drv = GOOD, abus_rx;
  cber_noack_t  noack = '0;
  logic [7:0]   hard_src = '0, fault_src = '0, req_l;
  logic [5:0]   fl = '0;
  logic [15:0]  avl_l;
  logic         ack_l, sup_l, flt_i, flt_o, flt_oe_n, dat_i, dat_o, dat_oe_n;
  logic         irq, fail, fail_ack, fill;
  int           err_total = 0, cmp_count = 0, cyc = 0;
  cber_tb_row_t rows [14];

  always #2 clock = ~clock;

  cber_unit u_cber_unit (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_drive(cmd_drive), .abus_drv(abus_drv), .abus_rx(abus_rx),
    .abus_valid(abus_valid), .req_drive(req_drive), .bus_request_lines(req_l),
    .ack_drive(ack_drive), .bus_command_acknowledge(ack_l), .sup_drive(sup_drive),
    .bus_arbitration_suppress(sup_l), .avl_drive(avl_drive), .bus_bank_available(avl_l),
    .noack(noack), .hard_src(hard_src), .fault_src(fault_src), .bus_fault_line_i(flt_i),
    .bus_fault_line_o(flt_o), .bus_fault_line_oe_n(flt_oe_n),
    .bus_data_error_line_i(dat_i), .bus_data_error_line_o(dat_o),
    .bus_data_error_line_oe_n(dat_oe_n), .system_machine_check_irq(irq),
    .cpu_fail_wire(fail), .cpu_fail_acknowledge(fail_ack), .fill_error(fill));

  cber_bus_model u_cber_bus_model (.clock(clock), .fl(fl), .nid(CTRL[2:0]), .vid(CTRL[7:4]),
    .abus_drv(abus_drv), .req_drive(req_drive), .ack_drive(ack_drive),
    .sup_drive(sup_drive), .avl_drive(avl_drive), .flt_o(flt_o), .flt_oe_n(flt_oe_n),
    .dat_o(dat_o), .dat_oe_n(dat_oe_n), .abus_rx(abus_rx), .req_lines(req_l),
    .ack_line(ack_l), .sup_line(sup_l), .avl_lines(avl_l), .flt_i(flt_i), .dat_i(dat_i));

  //////////////////////////////////////////////////////////////////////////////
  // one apb transfer; waits for pready, the cycle watchdog ends a dead wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
    end
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // one-cycle stimulus, then line, fail wire and register checks, then w1c
  task automatic inj(input cber_tb_row_t r);
    logic [31:0] v;
    logic        e;
    @(posedge clock);
    {abus_valid, avl_drive, sup_drive, ack_drive, req_drive, cmd_drive} <= r.dv;
    abus_drv <= (r.dv == 6'h20) ? 48'h0 : GOOD;
    fl <= r.fl;
    noack <= r.nk;
    hard_src <= r.hs;
    fault_src <= r.fs;
    @(posedge clock);
    {abus_valid, avl_drive, sup_drive, ack_drive, req_drive, cmd_drive} <= '0;
    abus_drv <= GOOD;
    fl <= '0;
    noack <= '0;
    hard_src <= '0;
    fault_src <= '0;
    #1;
    `CHK("fault_o", r.ex[2], flt_o)
    `CHK("fault_oe_n", !r.ex[2], flt_oe_n)
    `CHK("data_o", r.ex[1], dat_o)
    `CHK("data_oe_n", !r.ex[1], dat_oe_n)
    `CHK("fill", r.ex[0], fill)
    @(posedge clock);
    #1;
    `CHK("fail", r.ex[2] | r.fl[5], fail)
    `CHK("fail_ack", 1'b0, fail_ack)
    apb(1'b0, CBER_OFF_ERR, 32'h0, v, e);
    `CHK("err", r.err, v)
    `CHK("err_slverr", 1'b0, e)
    `CHK("irq", |r.err[23:16] | r.err[5], irq)
    // status shows the interrupt level with the lines idle again
    apb(1'b0, CBER_OFF_STAT, 32'h0, v, e);
    `CHK("stat", {1'b0, |r.err[23:16] | r.err[5], 2'b00}, v[3:0])
    apb(1'b1, CBER_OFF_ERR, 32'hffff_ffff, v, e);
  endtask : inj

  // state right after a reset release
  task automatic chk_rst;
    apb(1'b0, CBER_OFF_CTRL, 32'h0, rv, re);
    `CHK("ctrl", CBER_CTRL_RST, rv)
    apb(1'b0, CBER_OFF_ERR, 32'h0, rv, re);
    `CHK("err_rst", 32'h0, rv)
    `CHK("rst_lines", 3'b110, {flt_oe_n, dat_oe_n, irq})
  endtask : chk_rst

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////////////
  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_total++;
      finish_test();
    end
  end

  // main sequence: reset, table rows, every error source, awkward cases
  initial
  begin
    rows = '{
      '{6'h01, 6'h01, 4'h0, 8'h0, 8'h0, 32'h02, 3'b100},
      '{6'h02, 6'h02, 4'h0, 8'h0, 8'h0, 32'h04, 3'b100},
      '{6'h00, 6'h02, 4'h0, 8'h0, 8'h0, 32'h04, 3'b100},
      '{6'h04, 6'h04, 4'h0, 8'h0, 8'h0, 32'h08, 3'b000},
      '{6'h00, 6'h04, 4'h0, 8'h0, 8'h0, 32'h00, 3'b000},
      '{6'h08, 6'h08, 4'h0, 8'h0, 8'h0, 32'h10, 3'b100},
      '{6'h10, 6'h10, 4'h0, 8'h0, 8'h0, 32'h10, 3'b100},
      '{6'h20, 6'h00, 4'h0, 8'h0, 8'h0, 32'h01, 3'b100},
      '{6'h00, 6'h20, 4'h0, 8'h0, 8'h0, 32'h00, 3'b000},
      '{6'h00, 6'h00, 4'he, 8'h0, 8'h0, 32'h20, 3'b001},
      '{6'h00, 6'h00, 4'hc, 8'h0, 8'h0, 32'h20, 3'b000},
      '{6'h00, 6'h00, 4'h8, 8'h0, 8'h0, 32'h40, 3'b100},
      '{6'h00, 6'h00, 4'hd, 8'h0, 8'h0, 32'h00, 3'b000},
      '{6'h21, 6'h00, 4'h0, 8'h0, 8'h0, 32'h00, 3'b000}};
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    chk_rst();
    apb(1'b1, CBER_OFF_CTRL, 32'hffff_ffff, rv, re);
    apb(1'b0, CBER_OFF_CTRL, 32'h0, rv, re);
    `CHK("ctrl_mask", CBER_CTRL_MASK, rv)
    apb(1'b1, CBER_OFF_CTRL, CTRL, rv, re);
    $display("reset and control test done");
    foreach (rows[k])
      inj(rows[k]);
    $display("table test done");
    for (int i = 0; i < 8; i++)
    begin
      inj('{6'h0, 6'h0, 4'h0, 8'(1 << i), 8'h0, 32'h1 << (16 + i),
            {1'b0, CBER_HARD_DATA_MASK[i], 1'b0}});
      inj('{6'h0, 6'h0, 4'h0, 8'h0, 8'(1 << i), 32'h1 << (24 + i), 3'b100});
    end
    $display("source test done");
    // a source held across a clear must survive it
    hard_src <= 8'h02;
    apb(1'b1, CBER_OFF_ERR, 32'hffff_ffff, rv, re);
    hard_src <= 8'h00;
    apb(1'b0, CBER_OFF_ERR, 32'h0, rv, re);
    `CHK("set_wins", 32'h0002_0000, rv)
    apb(1'b1, CBER_OFF_ERR, 32'hffff_ffff, rv, re);
    $display("set over clear test done");
    apb(1'b0, 12'h00c, 32'h0, rv, re);
    `CHK("unmapped", 33'h1_0000_0000, {re, rv})
    @(posedge clock);
    rstn <= 1'b0;
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    chk_rst();
    // reset left a non-memory node: its bank-available check stays off
    inj('{6'h10, 6'h00, 4'h0, 8'h0, 8'h0, 32'h0, 3'b000});
    $display("unmapped and second reset test done");
    finish_test();
  end
endmodule : cber_unit_test
